// file: dapg_pkg.sv
package dapg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS = 4'h0;   // Sticky event flags, write one to clear
  localparam logic [3:0] OFS_MASK = 4'h1;     // Interrupt mask, same layout
  localparam logic [3:0] OFS_CTRL = 4'h2;     // Supply drop reset and threshold controls
  localparam logic [3:0] OFS_LEVEL = 4'h3;    // Held guard level and live state
  localparam logic [3:0] OFS_DBGCAP = 4'h4;   // Debug resource counts

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int ST_DROP = 0;     // Supply below selected threshold
  localparam int ST_REFUSE = 1;   // Programming command refused
  localparam int ST_NBITS = 2;

  // ----------------------------------------------------------------
  // Control bit positions and reset value
  // ----------------------------------------------------------------
  localparam int CT_RST_EN = 0;     // Supply drop forces chip reset
  localparam int CT_RST_SEL = 1;    // Which threshold forces reset
  localparam int CT_IRQ_SEL = 2;    // Which threshold raises the flag
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Guard patterns held in flash
  // ----------------------------------------------------------------
  localparam logic [31:0] PAT_LEVEL_ONE = 32'h12345678;
  localparam logic [31:0] PAT_LEVEL_TWO = 32'h87654321;
  localparam logic [31:0] PAT_LEVEL_THREE = 32'h43218765;
  localparam logic [31:0] PAT_NO_BOOT_PIN = 32'h4e697370;
  localparam logic [31:0] PAT_NO_SAMPLE = 32'h4e696e61;

  // ----------------------------------------------------------------
  // Debug resources
  // ----------------------------------------------------------------
  localparam logic [3:0] NUM_BREAKPOINTS = 4'h4;
  localparam logic [3:0] NUM_WATCHPOINTS = 4'h2;

  // Guard levels
  typedef enum logic [1:0] {
    GUARD_NONE,
    GUARD_ONE,
    GUARD_TWO,
    GUARD_THREE
  } dapg_level_t;

  // Programming command classes
  typedef enum logic [1:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_SECTOR_ERASE,
    CMD_FULL_ERASE
  } dapg_cmd_t;

  // Programming command carrier
  typedef struct packed {
    logic valid;
    dapg_cmd_t kind;
    logic [7:0] sector;
  } dapg_prog_t;

  // Register bus carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } dapg_bus_t;

endpackage

// file: dapg_gate.sv
// What this block does
// RULE1: Supply drop below threshold raises interrupt request
// RULE2: Supply drop visible as readable status bit
// RULE3: Selected threshold crossing forces chip reset
// RULE4: Flash pattern enables guard, selects level
// RULE5: Application flash calls always allowed
// RULE6: Separate setting disables boot pin entry
// RULE7: Level one: no debug, no sector 0
// RULE8: Level two: no debug, full erase only; the code also grants writes at level two
// RULE9: Level three: no debug, no programming
// RULE10: Level three ignores boot select pin
// RULE11: Setting stops boot pin sampling
// RULE12: Four breakpoints and two watchpoints
// RULE13: Reset low scan, reset high debug
// RULE14: Debug port off during chip reset
// RULE15: Tester erases, waits 250 us, lowers reset
// RULE16: Tester asserts test reset, then releases
// RULE17: Scan path carries no processor debug
// RULE18: Level latched at reset, held until next
//
// The implementer's own choices: the register addresses and the plain strobed port.
module dapg_gate (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire dapg_pkg::dapg_bus_t BUS_IN,
  output logic [31:0] RDATA_OUT,
  output logic IRQ_OUT,
  input wire logic [31:0] FLASH_WORD_IN,
  input wire logic DROP_LOW_IN,
  input wire logic DROP_HIGH_IN,
  input wire logic RESET_PIN_IN,
  input wire logic BOOT_SELECT_IN,
  input wire logic TEST_CLK_IN,
  input wire logic TEST_RESET_IN,
  input wire dapg_pkg::dapg_prog_t PROG_CMD_IN,
  input wire dapg_pkg::dapg_prog_t APP_CMD_IN,
  output logic PROG_GRANT_OUT,
  output logic APP_GRANT_OUT,
  output logic FORCE_RESET_OUT,
  output logic SWD_ENABLE_OUT,
  output logic SCAN_ENABLE_OUT,
  output logic SCAN_DEBUG_OUT,
  output logic BOOT_ENTRY_OUT,
  output logic TEST_CLK_EDGE_OUT
);
  import dapg_pkg::*;

  // ----------------------------------------------------------------
  // Synchronisers for pins
  // ----------------------------------------------------------------
  logic [1:0] s_low_r;    // Low threshold comparator
  logic [1:0] s_high_r;   // High threshold comparator
  logic [1:0] s_rst_r;    // Reset pin level
  logic [1:0] s_boot_r;   // Boot select pin
  logic [1:0] s_tck_r;    // Test clock
  logic [1:0] s_trst_r;   // Test reset
  logic tck_prev_r;       // Last synced test clock

  // Two stages each; only the second stage is read further
  always_ff @(posedge CLK_IN) begin
    s_low_r <= {s_low_r[0], DROP_LOW_IN};
    s_high_r <= {s_high_r[0], DROP_HIGH_IN};
    s_rst_r <= {s_rst_r[0], RESET_PIN_IN};
    s_boot_r <= {s_boot_r[0], BOOT_SELECT_IN};
    s_tck_r <= {s_tck_r[0], TEST_CLK_IN};
    s_trst_r <= {s_trst_r[0], TEST_RESET_IN};
  end

  // Test clock edge finder
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tck_prev_r <= 1'b0;
    end else begin
      tck_prev_r <= s_tck_r[1];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [ST_NBITS-1:0] status_r;   // Sticky events
  logic [7:0] mask_r;              // Interrupt mask
  logic [7:0] ctrl_r;              // Control bits
  dapg_level_t level_r;            // Held guard level
  logic no_boot_pin_r;             // Boot pin entry disabled
  logic no_sample_r;               // Boot pin not sampled
  logic loaded_r;                  // Level captured after release
  logic drop_irq;                  // Selected irq threshold crossed
  logic drop_rst;                  // Selected reset threshold crossed
  logic prog_ok;                   // Programming command allowed
  logic [ST_NBITS-1:0] set_ev;     // Event set terms
  logic [ST_NBITS-1:0] clr_ev;     // Write-one clears

  // Threshold selection
  assign drop_irq = ctrl_r[CT_IRQ_SEL] ? s_high_r[1] : s_low_r[1];
  assign drop_rst = ctrl_r[CT_RST_SEL] ? s_high_r[1] : s_low_r[1];

  // ----------------------------------------------------------------
  // Guard level capture
  // ----------------------------------------------------------------
  // Pattern read once after reset release, then held
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      loaded_r <= 1'b0;
      level_r <= GUARD_NONE;
      no_boot_pin_r <= 1'b0;
      no_sample_r <= 1'b0;
    end else if (!loaded_r) begin
      loaded_r <= 1'b1; // RULE18
      unique case (FLASH_WORD_IN) // RULE4
        PAT_LEVEL_ONE: level_r <= GUARD_ONE;
        PAT_LEVEL_TWO: level_r <= GUARD_TWO;
        PAT_LEVEL_THREE: level_r <= GUARD_THREE;
        default: level_r <= GUARD_NONE;
      endcase
      no_boot_pin_r <= (FLASH_WORD_IN == PAT_NO_BOOT_PIN); // RULE6
      no_sample_r <= (FLASH_WORD_IN == PAT_NO_SAMPLE); // RULE11
    end
  end

  // ----------------------------------------------------------------
  // Access gating
  // ----------------------------------------------------------------
  // Command filter per level
  always_comb begin
    prog_ok = 1'b0;
    unique case (level_r)
      GUARD_NONE: prog_ok = 1'b1;
      // No sector 0 writes or erases
      GUARD_ONE: prog_ok = (PROG_CMD_IN.kind == CMD_WRITE ||
                            PROG_CMD_IN.kind == CMD_SECTOR_ERASE) &&
                           (PROG_CMD_IN.sector != 8'h00); // RULE7
      // Full erase then reprogram
      GUARD_TWO: prog_ok = (PROG_CMD_IN.kind == CMD_FULL_ERASE ||
                            PROG_CMD_IN.kind == CMD_WRITE); // RULE8
      GUARD_THREE: prog_ok = 1'b0; // RULE9
    endcase
  end

  // Gating outputs, all registered
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      SWD_ENABLE_OUT <= 1'b0; // RULE14
      SCAN_ENABLE_OUT <= 1'b0;
      PROG_GRANT_OUT <= 1'b0;
      APP_GRANT_OUT <= 1'b0;
      BOOT_ENTRY_OUT <= 1'b0;
      TEST_CLK_EDGE_OUT <= 1'b0;
    end else begin
      // Debug only with pin high, guard open
      SWD_ENABLE_OUT <= loaded_r && s_rst_r[1] &&
                        level_r == GUARD_NONE; // RULE13 RULE7 RULE8 RULE9
      // Scan selected by low pin while test reset is low
      SCAN_ENABLE_OUT <= !s_rst_r[1] && !s_trst_r[1]; // RULE13
      // Programming path filtered by held level
      PROG_GRANT_OUT <= loaded_r && PROG_CMD_IN.valid && prog_ok;
      // Application calls never gated
      APP_GRANT_OUT <= APP_CMD_IN.valid; // RULE5
      BOOT_ENTRY_OUT <= loaded_r && s_boot_r[1] && !no_boot_pin_r &&
                        !no_sample_r && level_r != GUARD_THREE; // RULE6 RULE10 RULE11
      // Scan clock edge only while scan selected
      TEST_CLK_EDGE_OUT <= s_tck_r[1] && !tck_prev_r && SCAN_ENABLE_OUT;
    end
  end

  // Scan path never reaches the processor debug
  assign SCAN_DEBUG_OUT = 1'b0; // RULE17

  // ----------------------------------------------------------------
  // Forced reset on supply drop
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      FORCE_RESET_OUT <= 1'b0;
    end else begin
      FORCE_RESET_OUT <= ctrl_r[CT_RST_EN] && drop_rst; // RULE3
    end
  end

  // ----------------------------------------------------------------
  // Status, mask, control
  // ----------------------------------------------------------------
  assign set_ev = {PROG_CMD_IN.valid && !prog_ok && loaded_r, drop_irq};
  assign clr_ev = (BUS_IN.wr && BUS_IN.addr == OFS_STATUS) ?
                  BUS_IN.wdata[ST_NBITS-1:0] : '0;

  // Sticky flags, set beats clear
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~clr_ev) | set_ev; // RULE1 RULE2
    end
  end

  // Mask and control writes
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      mask_r <= MASK_RESET;
      ctrl_r <= CTRL_RESET;
    end else if (BUS_IN.wr) begin
      if (BUS_IN.addr == OFS_MASK) begin
        mask_r <= BUS_IN.wdata[7:0];
      end
      if (BUS_IN.addr == OFS_CTRL) begin
        ctrl_r <= BUS_IN.wdata[7:0];
      end
    end
  end

  // Level interrupt
  assign IRQ_OUT = |(status_r & mask_r[ST_NBITS-1:0]); // RULE1

  // Read data one cycle later, zero elsewhere
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 32'h0;
    end else if (BUS_IN.rd) begin
      unique case (BUS_IN.addr)
        OFS_STATUS: RDATA_OUT <= {30'h0, status_r}; // RULE2
        OFS_MASK: RDATA_OUT <= {24'h0, mask_r};
        OFS_CTRL: RDATA_OUT <= {24'h0, ctrl_r};
        OFS_LEVEL: RDATA_OUT <= {24'h0, s_rst_r[1], drop_irq, no_sample_r,
                                 no_boot_pin_r, loaded_r, 1'b0, level_r};
        OFS_DBGCAP: RDATA_OUT <= {24'h0, NUM_WATCHPOINTS, NUM_BREAKPOINTS}; // RULE12
        default: RDATA_OUT <= 32'h0;
      endcase
    end else begin
      RDATA_OUT <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_irq_follows;
    @(posedge CLK_IN) disable iff (RST_IN)
    drop_irq |=> (IRQ_OUT || !mask_r[ST_DROP]);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq missed"); // RULE1

  property p_status_sticky;
    @(posedge CLK_IN) disable iff (RST_IN)
    (status_r[ST_DROP] && !clr_ev[ST_DROP]) |=> status_r[ST_DROP];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("flag lost"); // RULE2

  property p_force_reset;
    @(posedge CLK_IN) disable iff (RST_IN)
    (ctrl_r[CT_RST_EN] && drop_rst) |=> FORCE_RESET_OUT;
  endproperty
  a_force_reset: assert property (p_force_reset) else $error("no forced reset"); // RULE3

  property p_app_open;
    @(posedge CLK_IN) disable iff (RST_IN)
    APP_CMD_IN.valid |=> APP_GRANT_OUT;
  endproperty
  a_app_open: assert property (p_app_open) else $error("application call blocked"); // RULE5

  property p_no_sector0;
    @(posedge CLK_IN) disable iff (RST_IN)
    (level_r == GUARD_ONE && PROG_CMD_IN.sector == 8'h00) |=> !PROG_GRANT_OUT;
  endproperty
  a_no_sector0: assert property (p_no_sector0) else $error("sector 0 granted"); // RULE7

  property p_swd_locked;
    @(posedge CLK_IN) disable iff (RST_IN)
    (level_r != GUARD_NONE) |=> !SWD_ENABLE_OUT;
  endproperty
  a_swd_locked: assert property (p_swd_locked) else $error("debug open"); // RULE9

  property p_boot_ignored;
    @(posedge CLK_IN) disable iff (RST_IN)
    (level_r == GUARD_THREE || no_boot_pin_r) |=> !BOOT_ENTRY_OUT;
  endproperty
  a_boot_ignored: assert property (p_boot_ignored) else $error("boot entry"); // RULE10

  property p_level_held;
    @(posedge CLK_IN) disable iff (RST_IN)
    loaded_r |=> $stable(level_r);
  endproperty
  a_level_held: assert property (p_level_held) else $error("level changed"); // RULE18

  property p_swd_needs_pin;
    @(posedge CLK_IN) disable iff (RST_IN)
    !s_rst_r[1] |=> !SWD_ENABLE_OUT;
  endproperty
  a_swd_needs_pin: assert property (p_swd_needs_pin) else $error("swd in scan"); // RULE13

  property p_swd_after_reset;
    @(posedge CLK_IN) RST_IN |=> !SWD_ENABLE_OUT;
  endproperty
  a_swd_after_reset: assert property (p_swd_after_reset) else $error("swd in reset"); // RULE14

  // Drop always lands in the status bit
  property p_drop_status;
    @(posedge CLK_IN) disable iff (RST_IN)
    drop_irq |=> status_r[ST_DROP];
  endproperty
  a_drop_status: assert property (p_drop_status) else $error("drop not flagged"); // RULE2

  // No forced reset while disabled
  property p_force_off;
    @(posedge CLK_IN) disable iff (RST_IN)
    !ctrl_r[CT_RST_EN] |=> !FORCE_RESET_OUT;
  endproperty
  a_force_off: assert property (p_force_off) else $error("forced reset while off"); // RULE3

  // Refused command leaves a sticky flag
  property p_refuse_flag;
    @(posedge CLK_IN) disable iff (RST_IN)
    (loaded_r && PROG_CMD_IN.valid && !prog_ok) |=> status_r[ST_REFUSE];
  endproperty
  a_refuse_flag: assert property (p_refuse_flag) else $error("refusal not flagged"); // RULE7

  // Level two refuses single sector erase
  property p_level_two;
    @(posedge CLK_IN) disable iff (RST_IN)
    (level_r == GUARD_TWO && PROG_CMD_IN.kind == CMD_SECTOR_ERASE) |=> !PROG_GRANT_OUT;
  endproperty
  a_level_two: assert property (p_level_two) else $error("sector erase granted"); // RULE8

  // Level three closes programming path
  property p_level_three;
    @(posedge CLK_IN) disable iff (RST_IN)
    (level_r == GUARD_THREE) |=> !PROG_GRANT_OUT;
  endproperty
  a_level_three: assert property (p_level_three) else $error("programming open"); // RULE9

  // Boot pin not sampled when disabled
  property p_no_sample;
    @(posedge CLK_IN) disable iff (RST_IN)
    no_sample_r |=> !BOOT_ENTRY_OUT;
  endproperty
  a_no_sample: assert property (p_no_sample) else $error("boot pin sampled"); // RULE11

  // Low pin without test reset selects scan
  property p_scan_low_pin;
    @(posedge CLK_IN) disable iff (RST_IN)
    (!s_rst_r[1] && !s_trst_r[1]) |=> SCAN_ENABLE_OUT;
  endproperty
  a_scan_low_pin: assert property (p_scan_low_pin) else $error("scan not selected"); // RULE13

  // Main scenarios
  c_irq: cover property (@(posedge CLK_IN) disable iff (RST_IN) IRQ_OUT);
  c_prog: cover property (@(posedge CLK_IN) disable iff (RST_IN) PROG_GRANT_OUT);
  c_lock: cover property (@(posedge CLK_IN) disable iff (RST_IN) level_r == GUARD_THREE);
  c_scan: cover property (@(posedge CLK_IN) disable iff (RST_IN) TEST_CLK_EDGE_OUT);
  c_frst: cover property (@(posedge CLK_IN) disable iff (RST_IN) FORCE_RESET_OUT);

endmodule

// file: dapg_probe.sv
// ----------------------------------------------------------------
// Scan tester on the far side of the test pins
// ----------------------------------------------------------------
module dapg_probe #(
  parameter int SETTLE_NS = 250000
) (
  output logic reset_pin_out,
  output logic test_clk_out,
  output logic test_reset_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: reset pin high, scan clock still
  initial begin
    reset_pin_out = 1'b1;
    test_clk_out = 1'b0;
    test_reset_out = 1'b0;
  end

  // Hold reset pin high, settle, then pull it low
  task automatic enter_scan();
    reset_pin_out = 1'b1;
    #(SETTLE_NS);
    reset_pin_out = 1'b0;
  endtask

  // Scan clock runs only inside a frame, 160 ns period
  task automatic clock_scan(input int n);
    #37;
    repeat (n) begin
      test_clk_out = 1'b1;
      #80;
      test_clk_out = 1'b0;
      #80;
    end
  endtask

  // Test reset first, then release the reset pin
  task automatic leave_scan();
    test_reset_out = 1'b1;
    #200;
    reset_pin_out = 1'b1;
    #200;
    test_reset_out = 1'b0;
  endtask
endmodule

// file: tb_dapg_gate.sv
module tb_dapg_gate;
  timeunit 1ns;
  timeprecision 1ps;
  import dapg_pkg::*;

  // ----------------------------------------------------------------
  // Signals and expectation tables
  // ----------------------------------------------------------------
  logic clk, rst, drop_lo, drop_hi, boot_sel, rst_pin, tck, trst;
  logic [31:0] flash_word, rdata;
  dapg_bus_t bus;
  dapg_prog_t prog_cmd, app_cmd;
  logic irq, prog_gnt, app_gnt, force_rst, swd_en, scan_en, scan_dbg, boot_ent, tck_edge;
  int error_cnt, comparisons, edge_cnt;
  logic [31:0] pats [6];
  logic [1:0] lv [6];
  logic [2:0] gn [6];
  logic bt [6];
  logic [1:0] fl [6];

  dapg_gate u_dapg_gate (.CLK_IN(clk), .RST_IN(rst), .BUS_IN(bus), .RDATA_OUT(rdata),
    .IRQ_OUT(irq), .FLASH_WORD_IN(flash_word), .DROP_LOW_IN(drop_lo), .DROP_HIGH_IN(drop_hi),
    .RESET_PIN_IN(rst_pin), .BOOT_SELECT_IN(boot_sel), .TEST_CLK_IN(tck),
    .TEST_RESET_IN(trst), .PROG_CMD_IN(prog_cmd), .APP_CMD_IN(app_cmd),
    .PROG_GRANT_OUT(prog_gnt), .APP_GRANT_OUT(app_gnt), .FORCE_RESET_OUT(force_rst),
    .SWD_ENABLE_OUT(swd_en),
    .SCAN_ENABLE_OUT(scan_en), .SCAN_DEBUG_OUT(scan_dbg), .BOOT_ENTRY_OUT(boot_ent),
    .TEST_CLK_EDGE_OUT(tck_edge));

  dapg_probe u_dapg_probe (.reset_pin_out(rst_pin), .test_clk_out(tck),
    .test_reset_out(trst));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count synced scan clock edges
  always @(posedge clk) begin
    if (tck_edge === 1'b1) begin
      edge_cnt++;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus <= '0;
    #1 chk(what, exp, rdata);
  endtask

  // Same request on both paths; application path always granted
  task automatic prog(input dapg_cmd_t k, input logic [7:0] s, input logic prog_exp);
    @(posedge clk);
    prog_cmd <= '{valid: 1'b1, kind: k, sector: s};
    app_cmd <= '{valid: 1'b1, kind: k, sector: s};
    @(posedge clk);
    prog_cmd <= '0;
    app_cmd <= '0;
    #1 chk("grants", {30'h0, prog_exp, 1'b1}, {30'h0, prog_gnt, app_gnt});
  endtask

  // Reset for 3 cycles with a flash word, then scramble the word
  task automatic boot(input logic [31:0] w);
    @(posedge clk);
    flash_word <= w;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("swd_in_reset", 32'h0, {31'h0, swd_en});
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    flash_word <= ~w;
    repeat (4) @(posedge clk);
  endtask

  task automatic wait_chk(input string what, input logic exp, input logic got_sel);
    repeat (4) @(posedge clk);
    #1 chk(what, {31'h0, exp}, {31'h0, got_sel ? force_rst : irq});
  endtask

  task automatic end_of_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog: tests need about 25k cycles, allow 40k
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    bus = '0;
    prog_cmd = '0;
    app_cmd = '0;
    flash_word = 32'h0;
    drop_lo = 1'b0;
    drop_hi = 1'b0;
    boot_sel = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    edge_cnt = 0;
    pats = '{32'h0, PAT_LEVEL_ONE, PAT_LEVEL_TWO, PAT_NO_BOOT_PIN, PAT_NO_SAMPLE,
      PAT_LEVEL_THREE};
    lv = '{2'd0, 2'd1, 2'd2, 2'd0, 2'd0, 2'd3};
    gn = '{3'b111, 3'b010, 3'b111, 3'b111, 3'b111, 3'b000};
    bt = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    fl = '{2'b00, 2'b00, 2'b00, 2'b01, 2'b10, 2'b00};
    // Every guard pattern, level held after word changes
    for (int i = 0; i < 6; i++) begin
      boot(pats[i]);
      rd(OFS_LEVEL, {24'h0, 2'b10, fl[i], 2'b10, lv[i]}, "level");
      chk("level_held", {30'h0, lv[i]}, {30'h0, rdata[1:0]});
      chk("swd", {31'h0, lv[i] == 2'd0}, {31'h0, swd_en});
      chk("boot_entry", {31'h0, bt[i]}, {31'h0, boot_ent});
      prog(CMD_WRITE, 8'h00, gn[i][2]);
      prog(CMD_WRITE, 8'h01, gn[i][1]);
      prog(CMD_FULL_ERASE, 8'h00, gn[i][0]);
      prog(CMD_SECTOR_ERASE, 8'h02, lv[i] < 2'd2);
      prog(CMD_READ, 8'h05, lv[i] == 2'd0);
    end
    rd(OFS_STATUS, 32'h2, "refused");
    wr(OFS_STATUS, 32'h2);
    rd(OFS_STATUS, 32'h0, "status_clr");
    rd(OFS_DBGCAP, {24'h0, NUM_WATCHPOINTS, NUM_BREAKPOINTS}, "dbgcap");
    rd(4'hf, 32'h0, "unmapped");
    // Supply drop: interrupt, status, forced reset
    boot(32'h0);
    wr(OFS_MASK, 32'h1);
    drop_lo <= 1'b1;
    wait_chk("irq", 1'b1, 1'b0);
    rd(OFS_STATUS, 32'h1, "drop_status");
    wr(OFS_MASK, 32'h0);
    wait_chk("irq_masked", 1'b0, 1'b0);
    wr(OFS_CTRL, 32'h1);
    wait_chk("force_low", 1'b1, 1'b1);
    wr(OFS_CTRL, 32'h3);
    wait_chk("force_sel_high", 1'b0, 1'b1);
    drop_hi <= 1'b1;
    wait_chk("force_high", 1'b1, 1'b1);
    drop_lo <= 1'b0;
    drop_hi <= 1'b0;
    wait_chk("force_gone", 1'b0, 1'b1);
    wr(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, 32'h0, "drop_clr");
    // Interrupt threshold select picks the high comparator
    wr(OFS_CTRL, 32'h4);
    wr(OFS_MASK, 32'h1);
    drop_lo <= 1'b1;
    wait_chk("irq_sel_low", 1'b0, 1'b0);
    drop_lo <= 1'b0;
    drop_hi <= 1'b1;
    wait_chk("irq_sel_high", 1'b1, 1'b0);
    drop_hi <= 1'b0;
    wait_chk("irq_sticky", 1'b1, 1'b0);
    wr(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, 32'h0, "sel_clr");
    // Boundary scan session
    u_dapg_probe.enter_scan();
    wait_chk("irq_idle", 1'b0, 1'b0);
    chk("scan_on", 32'h2, {30'h0, scan_en, swd_en});
    edge_cnt = 0;
    u_dapg_probe.clock_scan(8);
    wait_chk("irq_idle", 1'b0, 1'b0);
    chk("scan_edges", 32'd8, edge_cnt);
    chk("scan_debug", 32'h0, {31'h0, scan_dbg});
    u_dapg_probe.leave_scan();
    wait_chk("irq_idle", 1'b0, 1'b0);
    chk("swd_back", 32'h1, {30'h0, scan_en, swd_en});
    end_of_test();
  end
endmodule
